// ==== rtl/fprt_map.vh ====
// Constants for the fault routing and tracking block: register codes,
// field positions and reset values. Assumes inclusion by the one RTL file.
`ifndef FPRT_MAP_VH
`define FPRT_MAP_VH
`define FPRT_NCH 4
`define FPRT_REG_W 8
`define FPRT_SEL_ROUTE 1'b0
`define FPRT_SEL_TRACK 1'b1
`define FPRT_ROUTE_RST 8'h00
`define FPRT_TRACK_RST 8'h00
`define FPRT_HI_LSB 4
`define FPRT_LO_LSB 0
`define FPRT_SHARE_SYNC_RST 2'h3
`define FPRT_VIN_SYNC_RST 2'h0
`define FPRT_PIN_RST 1'b0
`define FPRT_CH_RST 4'h0
`endif

// ==== rtl/fprt_core.v ====
// Fault-to-auxiliary-pin routing and tracking-slave control, four channels.
// Assumes the command decoder presents one-cycle write strobes with data,
// and that fault, sequencing and restore events are clocked on i_ref_clk
// except the share clock and input voltage comparator, which are pins.
module fprt_core (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_resetn,
	// Register writes and reads
	input wire i_wr_en,
	input wire i_wr_sel,
	input wire [7:0] i_wr_data,
	output reg [7:0] o_route_rd,
	output reg [7:0] o_track_rd,
	// Per-channel fault and phase inputs
	input wire [3:0] i_ov_fault,
	input wire [3:0] i_oc_fault,
	input wire [3:0] i_uc_fault,
	input wire [3:0] i_chan_down,
	input wire [3:0] i_in_rise,
	input wire [3:0] i_in_ton_max,
	input wire [3:0] i_in_toff_delay,
	// System events
	input wire i_input_voltage_sense_low,
	input wire i_share_clk,
	input wire i_restore_all,
	input wire i_wpu_disable,
	// Auxiliary fault pin drive
	output reg o_aux_fault_pd,
	output reg o_aux_fault_wpu,
	// Sequencing requests and masks
	output reg [3:0] o_seq_off,
	output reg [3:0] o_uv_uc_mask
);
`include "fprt_map.vh"

	// Stored configuration and its next values.
	reg [7:0] route_r;
	reg [7:0] route_nxt;
	reg [7:0] track_r;
	reg [7:0] track_nxt;

	// Two-stage synchronisers for the two pin inputs.
	reg [1:0] share_sync_r;
	reg [1:0] vin_sync_r;

	// Next values of the registered outputs.
	reg [7:0] route_rd_nxt;
	reg [7:0] track_rd_nxt;
	reg pd_nxt;
	reg wpu_nxt;
	reg [3:0] seq_off_nxt;
	reg [3:0] mask_nxt;

	// Field views of the two configuration registers.
	wire [3:0] overcurrent_route_enable;
	wire [3:0] overvoltage_route_enable;
	wire [3:0] undercurrent_route_enable;
	wire [3:0] tracking_slave_enable;

	// Per-channel fault terms and their combination.
	wire [3:0] oc_hit;
	wire [3:0] ov_hit;
	wire [3:0] uc_hit;
	wire [3:0] routed;
	wire any_routed;

	// Tracking group terms.
	wire [3:0] phase_mask;
	wire [3:0] slave_off_mask;
	wire [3:0] chan_loss;
	wire share_low;
	wire vin_low;
	wire group_down;
	wire sys_event;
	wire take_down;

	assign overcurrent_route_enable =
		route_r[`FPRT_HI_LSB +: `FPRT_NCH];
	assign overvoltage_route_enable =
		route_r[`FPRT_LO_LSB +: `FPRT_NCH];
	assign undercurrent_route_enable =
		track_r[`FPRT_HI_LSB +: `FPRT_NCH];
	assign tracking_slave_enable =
		track_r[`FPRT_LO_LSB +: `FPRT_NCH];

	// Each channel's enabled faults fold into one pull-down term.
	genvar n;
	generate
		for (n = 0; n < `FPRT_NCH; n = n + 1) begin : g_ch
			assign oc_hit[n] =
				overcurrent_route_enable[n] & i_oc_fault[n];
			assign ov_hit[n] =
				overvoltage_route_enable[n] & i_ov_fault[n];
			assign uc_hit[n] =
				undercurrent_route_enable[n] & i_uc_fault[n];
			assign routed[n] =
				oc_hit[n] | ov_hit[n] | uc_hit[n];
			assign chan_loss[n] =
				i_chan_down[n] | i_oc_fault[n] | i_ov_fault[n];
			assign phase_mask[n] =
				i_in_rise[n] | i_in_ton_max[n];
			assign slave_off_mask[n] =
				tracking_slave_enable[n] & i_in_toff_delay[n];
		end
	endgenerate

	assign any_routed = |routed;
	// Any channel lost, slave or not, takes every tracking slave off, so a
	// slave never keeps tracking a master that is already falling.
	assign group_down = |chan_loss;
	assign share_low = ~share_sync_r[1];
	assign vin_low = vin_sync_r[1];
	assign sys_event = vin_low | share_low | i_restore_all;
	assign take_down = group_down | sys_event;

	// Pin inputs are synchronised; only the second stage is read.
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			share_sync_r <= `FPRT_SHARE_SYNC_RST;
		end else begin
			share_sync_r <= {share_sync_r[0], i_share_clk};
		end
	end

	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			vin_sync_r <= `FPRT_VIN_SYNC_RST;
		end else begin
			vin_sync_r <= {vin_sync_r[0], i_input_voltage_sense_low};
		end
	end

	// Write decode: the select picks one register, the other holds.
	always @* begin
		route_nxt = route_r;
		track_nxt = track_r;
		if (i_wr_en && (i_wr_sel == `FPRT_SEL_ROUTE)) begin
			route_nxt = i_wr_data;
		end else if (i_wr_en && (i_wr_sel == `FPRT_SEL_TRACK)) begin
			track_nxt = i_wr_data;
		end
	end

	// Registers store every bit and act from the next cycle.
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			route_r <= `FPRT_ROUTE_RST;
		end else begin
			route_r <= route_nxt;
		end
	end

	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			track_r <= `FPRT_TRACK_RST;
		end else begin
			track_r <= track_nxt;
		end
	end

	// Outputs are registered, adding one cycle from fault to pin.
	always @* begin
		route_rd_nxt = route_r;
		track_rd_nxt = track_r;
		pd_nxt = any_routed;
		wpu_nxt = ~i_wpu_disable & ~any_routed;
		seq_off_nxt = tracking_slave_enable &
			{`FPRT_NCH{take_down}};
		mask_nxt = phase_mask | slave_off_mask;
	end

	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_route_rd <= `FPRT_ROUTE_RST;
		end else begin
			o_route_rd <= route_rd_nxt;
		end
	end

	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_track_rd <= `FPRT_TRACK_RST;
		end else begin
			o_track_rd <= track_rd_nxt;
		end
	end

	// Fast pull-down drive of the auxiliary fault pin.
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_aux_fault_pd <= `FPRT_PIN_RST;
		end else begin
			o_aux_fault_pd <= pd_nxt;
		end
	end

	// The weak pull-up yields whenever any enabled fault pulls low.
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_aux_fault_wpu <= `FPRT_PIN_RST;
		end else begin
			o_aux_fault_wpu <= wpu_nxt;
		end
	end

	// Sequence-off requests stay up while their cause stands.
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_seq_off <= `FPRT_CH_RST;
		end else begin
			o_seq_off <= seq_off_nxt;
		end
	end

	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_uv_uc_mask <= `FPRT_CH_RST;
		end else begin
			o_uv_uc_mask <= mask_nxt;
		end
	end
endmodule

// ==== verification/fprt_properties.sv ====
// Checker for fprt_core, watching only its ports.
// Assumes the bench binds it to every instance of the core.
module fprt_properties(input wire i_ref_clk,i_resetn,i_wr_en,i_wr_sel,
	input wire [7:0] i_wr_data,o_route_rd,o_track_rd,
	input wire [3:0] i_ov_fault,i_oc_fault,i_uc_fault,i_chan_down,i_in_rise,
	input wire [3:0] i_in_ton_max,i_in_toff_delay,o_seq_off,o_uv_uc_mask,
	input wire i_input_voltage_sense_low,i_share_clk,i_restore_all,
	input wire i_wpu_disable,o_aux_fault_pd,o_aux_fault_wpu);
timeunit 1ns; timeprecision 1ns;
default clocking @(posedge i_ref_clk); endclocking
default disable iff (!i_resetn);
// Three quiet cycles let the two-stage pin synchronisers drain.
wire calm = !i_restore_all && i_share_clk && !i_input_voltage_sense_low
	&& !(|{i_chan_down,i_oc_fault,i_ov_fault});
wire [3:0] up = i_in_rise | i_in_ton_max;
AST_PDNONE: assert property (!(|{i_ov_fault,i_oc_fault,i_uc_fault}) |=>
	!o_aux_fault_pd) else $error("pull-down with no fault");
AST_WPUPD: assert property (o_aux_fault_wpu |-> !o_aux_fault_pd)
	else $error("pull-up while pulled low");
AST_WPUDIS: assert property (i_wpu_disable |=> !o_aux_fault_wpu)
	else $error("pull-up while disabled");
AST_RDR: assert property (i_wr_en && !i_wr_sel |=> ##1
	o_route_rd == $past(i_wr_data,2)) else $error("route readback");
AST_RDT: assert property (i_wr_en && i_wr_sel |=> ##1
	o_track_rd == $past(i_wr_data,2)) else $error("track readback");
AST_SEQQ: assert property (calm[*3] |=> o_seq_off == 4'h0)
	else $error("sequence off without cause");
AST_SEQR: assert property ((!i_wr_en)[*2] ##1 i_restore_all |=>
	o_seq_off == $past(o_track_rd[3:0])) else $error("restore group");
AST_MASK1: assert property (|up |=> (o_uv_uc_mask & $past(up)) ==
	$past(up)) else $error("mask missing in rise");
AST_MASK0: assert property (!(|{up,i_in_toff_delay}) |=>
	o_uv_uc_mask == 4'h0) else $error("mask without phase");
endmodule

// ==== verification/fprt_conv.sv ====
// Converter model: a slave asked to go down sits in its off delay.
// Assumes it shares the core's clock and reset.
module fprt_conv(input wire i_ref_clk,i_resetn,input wire [3:0] i_seq_off,
	output logic [3:0] o_toff);
timeunit 1ns; timeprecision 1ns;
// It never drops a slave early, so the group stays in step.
always @(posedge i_ref_clk or negedge i_resetn)
	if (!i_resetn) o_toff <= 4'h0; else o_toff <= i_seq_off;
endmodule

// ==== verification/test_fault_pin_routing_and_tracking.sv ====
// Self-checking bench for fprt_core with the converter model.
// Assumes the core, checker and model are compiled first.
module test_fault_pin_routing_and_tracking;
timeunit 1ns; timeprecision 1ns;
logic clk=0,rn=0,we=0,ws=0,vl=0,sc=1,ra=0,wd=0;
logic [7:0] d=8'h00;
logic [3:0] ov=0,oc=0,uc=0,cd=0,ri=0,tm=0;
wire [3:0] toff,so,mk;
wire [7:0] rr,tr;
wire pd,wpu;
int errors=0,num_checks=0;
always #20 clk=~clk;
fprt_core fprt_core_i(.i_ref_clk(clk),.i_resetn(rn),.i_wr_en(we),
	.i_wr_sel(ws),.i_wr_data(d),.o_route_rd(rr),.o_track_rd(tr),
	.i_ov_fault(ov),.i_oc_fault(oc),.i_uc_fault(uc),.i_chan_down(cd),
	.i_in_rise(ri),.i_in_ton_max(tm),.i_in_toff_delay(toff),
	.i_input_voltage_sense_low(vl),.i_share_clk(sc),.i_restore_all(ra),
	.i_wpu_disable(wd),.o_aux_fault_pd(pd),.o_aux_fault_wpu(wpu),
	.o_seq_off(so),.o_uv_uc_mask(mk));
fprt_conv fprt_conv_i(.i_ref_clk(clk),.i_resetn(rn),.i_seq_off(so),
	.o_toff(toff));
task automatic chk(input logic [7:0] g,e);
	num_checks++;
	if (g !== e) begin
		errors++;
		$display("BAD %0t got %h exp %h",$time,g,e);
	end
endtask
task automatic cyc(input int n); repeat (n) @(posedge clk); #1; endtask
task automatic wr(input logic s,input logic [7:0] v);
	@(posedge clk); we<=1; ws<=s; d<=v; @(posedge clk); we<=0; cyc(2);
endtask
task automatic t_route;
	for (int b=0; b<12; b++) begin
		wr(b>7,8'h01<<(b>7 ? b-4 : b));
		chk(b>7 ? tr : rr,8'h01<<(b>7 ? b-4 : b));
		@(posedge clk); {uc,oc,ov}<=12'h001<<b; cyc(2);
		chk({6'h0,pd,wpu},8'h02);
		@(posedge clk); {uc,oc,ov}<=12'h001<<((b+1)%12); cyc(2);
		chk({6'h0,pd,wpu},8'h01);
	end
	@(posedge clk); {uc,oc,ov}<=12'h000; wd<=1; cyc(2);
	chk({7'h0,wpu},8'h00);
	@(posedge clk); wd<=0;
endtask
task automatic t_track;
	wr(1,8'h05);
	for (int e=0; e<4; e++) begin
		@(posedge clk); ra<=e==0; vl<=e==1; sc<=e!=2; cd<=(e==3)?4'h2:4'h0;
		cyc(6); chk({4'h0,so},8'h05);
		chk({4'h0,mk},8'h05);
		@(posedge clk); ra<=0; vl<=0; sc<=1; cd<=4'h0; cyc(6);
		chk({4'h0,so},8'h00);
	end
	@(posedge clk); ri<=4'h8; tm<=4'h2; cyc(2); chk({4'h0,mk},8'h0a);
	@(posedge clk); ri<=4'h0; tm<=4'h0;
endtask
task automatic give_verdict;
	$display("checks %0d errors %0d",num_checks,errors);
	if (errors == 0 && num_checks > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
initial begin #100000; errors++; give_verdict; end
initial begin
	repeat (2) @(posedge clk);
	rn<=1;
	t_route;
	t_track;
	give_verdict;
end
endmodule
bind fprt_core fprt_properties fprt_properties_i(.*);
